/* dv/dai_top_sva.sv */
`timescale 1ns/10ps
module dai_top_sva
#(parameter CTX_W = 32)
(
   input aclk,
   input aresetn,
   input s_axi_bvalid,
   input s_axi_bready,
   input s_axi_rvalid,
   input s_axi_rready,
   input chan_active,
   input reload_pulse,
   input [CTX_W-1:0] work_ctx0
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
   else $error("bvalid dropped");
a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
   else $error("rvalid dropped");
a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
   else $error("bvalid repeated");
a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
   else $error("rvalid repeated");
a_reload_single: assert property (reload_pulse |=> !reload_pulse)
   else $error("reload too long");
a_reload_active: assert property (reload_pulse |-> chan_active)
   else $error("reload while idle");
a_work_steady: assert property ($changed(work_ctx0) |-> reload_pulse || $rose(chan_active))
   else $error("work set moved");
a_stop_quiet: assert property ($fell(chan_active) |-> !reload_pulse)
   else $error("reload at stop");
cover property (reload_pulse);
cover property ($fell(chan_active));
cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* dv/dai_top_tb_top.sv */
`timescale 1ns/10ps
module dai_top_tb_top;
logic aclk = 1'b0, aresetn = 1'b0, block_done = 1'b0, s_axi_bready = 1'b0;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
logic [31:0] s_axi_wdata = 32'h0;
logic [3:0] s_axi_wstrb = 4'hf;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire chan_active, reload_pulse;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata, work_ctx0, work_ctx1;
int errors, checks_done;
dai_top u_dai_top (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .block_done(block_done),
   .chan_active(chan_active),
   .reload_pulse(reload_pulse),
   .work_ctx0(work_ctx0),
   .work_ctx1(work_ctx1)
);
////////////////////////////////
task chk(input [31:0] g, input [31:0] e);
   checks_done++;
   errors += (g !== e);
   if (g !== e) $display("[FAIL] %0t %h %h", $time, g, e);
endtask
task wr(input [7:0] a, input [31:0] d);
   s_axi_awaddr <= a;
   s_axi_wdata <= d;
   {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
   while (s_axi_bvalid !== 1'b1)
   begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
   end
   chk({30'h0, s_axi_bresp}, 32'h0);
   s_axi_bready <= 1'b0;
   @(posedge aclk);
endtask
// Response code folded into bits 31:30
task rd(input [7:0] a, input [31:0] e);
   s_axi_araddr <= a;
   {s_axi_arvalid, s_axi_rready} <= 2'h3;
   while (s_axi_rvalid !== 1'b1)
   begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
   end
   chk({s_axi_rresp, s_axi_rdata[29:0]}, e);
   s_axi_rready <= 1'b0;
   @(posedge aclk);
endtask
task blk(input e);
   block_done <= 1'b1;
   @(posedge aclk);
   block_done <= 1'b0;
   @(posedge aclk);
   // Copy must land on the very edge that sees block end
   chk({31'h0, reload_pulse}, {31'h0, e});
endtask
task complete_run;
   if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
   else
      $display("TESTS FAILED");
   $finish;
endtask
////////////////////////////////
initial forever #2 aclk = ~aclk;
initial
begin
   #40000;
   errors++;
   complete_run;
end
initial
begin
   repeat (12) @(posedge aclk);
   aresetn <= 1'b1;
   repeat (2) @(posedge aclk);
   rd(8'h00, 32'h0);
   rd(8'h40, 32'h8000_0000);
   wr(8'h04, 32'ha1);
   wr(8'h08, 32'hb2);
   wr(8'h00, 32'h1);
   chk(work_ctx0, 32'ha1);
   chk(work_ctx1, 32'hb2);
   rd(8'h0c, 32'ha1);
   blk(1'b0);
   chk({31'h0, chan_active}, 32'h0);
   wr(8'h00, 32'h301);
   wr(8'h04, 32'hc3);
   chk(work_ctx0, 32'ha1);
   blk(1'b1);
   chk(work_ctx0, 32'hc3);
   chk({31'h0, chan_active}, 32'h1);
   wr(8'h00, 32'h101);
   wr(8'h04, 32'hd4);
   blk(1'b0);
   rd(8'h14, 32'h3);
   chk(work_ctx0, 32'hc3);
   wr(8'h00, 32'h901);
   chk(work_ctx0, 32'hd4);
   rd(8'h00, 32'h101);
   wr(8'h04, 32'he5);
   wr(8'h00, 32'h901);
   blk(1'b1);
   chk(work_ctx0, 32'he5);
   wr(8'h00, 32'h201);
   chk({31'h0, chan_active}, 32'h1);
   blk(1'b0);
   chk({31'h0, chan_active}, 32'h0);
   chk(work_ctx0, 32'he5);
   rd(8'h00, 32'h200);
   wr(8'h00, 32'h301);
   wr(8'h00, 32'h300);
   chk({31'h0, chan_active}, 32'h0);
   complete_run;
end
endmodule
bind dai_top dai_top_sva #(.CTX_W(CTX_W)) u_dai_top_sva (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .chan_active(chan_active),
   .reload_pulse(reload_pulse),
   .work_ctx0(work_ctx0)
);

/* shared/dai_defs.vh */
`ifndef DAI_DEFS_VH
`define DAI_DEFS_VH
// Register byte offsets
`define DAI_OFF_CTRL 8'h00
`define DAI_OFF_CFG0 8'h04
`define DAI_OFF_CFG1 8'h08
`define DAI_OFF_WRK0 8'h0C
`define DAI_OFF_WRK1 8'h10
`define DAI_OFF_STAT 8'h14
// Channel control field positions
`define DAI_BIT_EN 0
`define DAI_BIT_AUTO 8
`define DAI_BIT_REPEAT 9
`define DAI_BIT_PDONE 11
// Status field positions
`define DAI_BIT_ACTIVE 0
`define DAI_BIT_WAIT 1
// Reset values and AXI responses
`define DAI_CTRL_RST 16'h0000
`define DAI_CTX_RST 32'h0000_0000
`define DAI_RESP_OKAY 2'b00
`define DAI_RESP_SLVERR 2'b10
`endif

/* src/dai_top.v */
// Functional notes
// [R1] Channel has configuration and working register sets
// [R2] Programming-done flag at control bit 11
// [R3] Config rewrites never disturb running working set
// [R4] Block end copies config into working set
// [R5] Hardware clears programming-done flag after copy
// [R6] Software finishes config writes before the copy
// [R7] Software polls flag for zero before reprogramming
// [R8] Software clears repeat, then sets flag
// [R9] Repeat bit 9 matters only with auto reload
// [R10] Repeat zero: copy waits for flag one
// [R11] Repeat one: copy immediately regardless of flag
// [R12] No auto reload: disable channel at block end
// [R13] Auto reload: recopy and re-enable each block
// [R14] Clearing auto stops after block; enable stops now
// [R15] Flag already set: copy with no wait
`timescale 1ns/10ps
`include "dai_defs.vh"
module dai_top
#(
   parameter CTX_W = 32
)
(
   aclk,
   aresetn,
   s_axi_awaddr, s_axi_awvalid, s_axi_awready,
   s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_wready,
   s_axi_bresp, s_axi_bvalid, s_axi_bready,
   s_axi_araddr, s_axi_arvalid, s_axi_arready,
   s_axi_rdata, s_axi_rresp, s_axi_rvalid, s_axi_rready,
   block_done,
   chan_active,
   reload_pulse,
   work_ctx0,
   work_ctx1
);
input wire aclk;
input wire aresetn;
input wire [7:0] s_axi_awaddr;
input wire s_axi_awvalid;
output reg s_axi_awready;
input wire [31:0] s_axi_wdata;
input wire [3:0] s_axi_wstrb;
input wire s_axi_wvalid;
output reg s_axi_wready;
output reg [1:0] s_axi_bresp;
output reg s_axi_bvalid;
input wire s_axi_bready;
input wire [7:0] s_axi_araddr;
input wire s_axi_arvalid;
output reg s_axi_arready;
output reg [31:0] s_axi_rdata;
output reg [1:0] s_axi_rresp;
output reg s_axi_rvalid;
input wire s_axi_rready;
input wire block_done;
output reg chan_active;
output reg reload_pulse;
output reg [CTX_W-1:0] work_ctx0;
output reg [CTX_W-1:0] work_ctx1;

////////////////////////////////////////////////////////////////////////////////
// Write channel: address and data latched in either order
reg [7:0] awaddr_r;
reg aw_have_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg w_have_r;
reg [15:0] ctrl_r;
reg [CTX_W-1:0] cfg0_r;
reg [CTX_W-1:0] cfg1_r;
reg wait_r;
wire wr_fire;
wire ctrl_wr;
wire copy_now;
wire done_hit;
wire [15:0] ctrl_wval;

assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
assign ctrl_wr = wr_fire && (awaddr_r == `DAI_OFF_CTRL);
assign ctrl_wval = {wstrb_r[1] ? wdata_r[15:8] : ctrl_r[15:8],
                    wstrb_r[0] ? wdata_r[7:0] : ctrl_r[7:0]};
// Block end only counts while running
assign done_hit = block_done && chan_active;
// Flag seen in the same cycle as block end avoids an extra wait
assign copy_now = chan_active && ctrl_r[`DAI_BIT_EN] && ctrl_r[`DAI_BIT_AUTO] &&
                  (done_hit || wait_r) &&
                  (ctrl_r[`DAI_BIT_REPEAT] || ctrl_r[`DAI_BIT_PDONE]); // [R9] [R10] [R11] [R15]

always @(posedge aclk)
begin
   if (!aresetn)
   begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DAI_RESP_OKAY;
   end
   else
   begin
      s_axi_awready <= !aw_have_r && !s_axi_awready;
      s_axi_wready <= !w_have_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         s_axi_bvalid <= 1'b1;
         case (awaddr_r)
            `DAI_OFF_CTRL, `DAI_OFF_CFG0, `DAI_OFF_CFG1: s_axi_bresp <= `DAI_RESP_OKAY;
            default: s_axi_bresp <= `DAI_RESP_SLVERR;
         endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Control, configuration and working sets
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      ctrl_r <= `DAI_CTRL_RST;
      cfg0_r <= {CTX_W{1'b0}};
      cfg1_r <= {CTX_W{1'b0}};
      work_ctx0 <= {CTX_W{1'b0}};
      work_ctx1 <= {CTX_W{1'b0}};
      chan_active <= 1'b0;
      reload_pulse <= 1'b0;
      wait_r <= 1'b0;
   end
   else
   begin
      reload_pulse <= 1'b0;
      // Working set untouched by config writes while running
      if (wr_fire && awaddr_r == `DAI_OFF_CFG0)
         cfg0_r <= wdata_r[CTX_W-1:0]; // [R1] [R3]
      if (wr_fire && awaddr_r == `DAI_OFF_CFG1)
         cfg1_r <= wdata_r[CTX_W-1:0]; // [R1] [R3]
      if (ctrl_wr)
         ctrl_r <= ctrl_wval; // [R2]
      if (ctrl_wr && !ctrl_r[`DAI_BIT_EN] && ctrl_wval[`DAI_BIT_EN])
      begin
         // Enable edge loads the context and starts
         work_ctx0 <= cfg0_r;
         work_ctx1 <= cfg1_r;
         chan_active <= 1'b1;
         wait_r <= 1'b0;
      end
      else if (ctrl_wr && !ctrl_wval[`DAI_BIT_EN])
      begin
         chan_active <= 1'b0; // [R14]
         wait_r <= 1'b0;
      end
      else if (copy_now)
      begin
         work_ctx0 <= cfg0_r; // [R4] [R13]
         work_ctx1 <= cfg1_r; // [R4] [R13]
         reload_pulse <= 1'b1;
         wait_r <= 1'b0;
         // Clear of flag beats a same-cycle software write, as the copy is the event
         ctrl_r[`DAI_BIT_PDONE] <= 1'b0; // [R5]
      end
      else if (done_hit && ctrl_r[`DAI_BIT_AUTO])
         wait_r <= 1'b1; // [R10]
      else if (done_hit || (wait_r && !ctrl_r[`DAI_BIT_AUTO]))
      begin
         // Auto cleared mid block or while waiting: stop
         chan_active <= 1'b0; // [R12] [R14]
         ctrl_r[`DAI_BIT_EN] <= 1'b0; // [R12]
         wait_r <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DAI_RESP_OKAY;
   end
   else
   begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `DAI_RESP_OKAY;
         case (s_axi_araddr)
            `DAI_OFF_CTRL: s_axi_rdata <= {16'h0000, ctrl_r};
            `DAI_OFF_CFG0: s_axi_rdata <= cfg0_r;
            `DAI_OFF_CFG1: s_axi_rdata <= cfg1_r;
            `DAI_OFF_WRK0: s_axi_rdata <= work_ctx0;
            `DAI_OFF_WRK1: s_axi_rdata <= work_ctx1;
            `DAI_OFF_STAT: s_axi_rdata <= {30'h0000_0000, wait_r, chan_active};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `DAI_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
end
endmodule
